// ---- shared/cis_pkg.sv ----
// Package for the comparator input select register bank.
// Assumes an 8-bit special function register access port on sys_clk.
`default_nettype none

package cis_pkg;

  // Register addresses in the special function register space
  localparam logic [7:0] CIS_ADDR_B = 8'h9E;
  localparam logic [7:0] CIS_ADDR_A = 8'h9F;

  // Reset value of both select registers
  localparam logic [7:0] CIS_RESET_SEL = 8'hFF;

  // Field positions inside a select register
  localparam int CIS_NEG_LSB = 4;
  localparam int CIS_POS_LSB = 0;
  localparam int CIS_NIB_W = 4;

  // Width of the one-hot select buses (one line per nibble code)
  localparam int CIS_MUX_W = 16;

  // Named nibble codes; touch and half are shared by both inputs, the rest belong to one input
  localparam logic [3:0] CIS_CODE_TOUCH = 4'hC;
  localparam logic [3:0] CIS_CODE_HALF = 4'hD;
  localparam logic [3:0] CIS_CODE_NEG_DIG = 4'hE;
  localparam logic [3:0] CIS_CODE_NEG_GND = 4'hF;
  localparam logic [3:0] CIS_CODE_POS_BAT = 4'hE;
  localparam logic [3:0] CIS_CODE_POS_MAIN = 4'hF;
  localparam logic [3:0] CIS_NEG_LAST_PIN = 4'h6;
  localparam logic [3:0] CIS_POS_LAST_PIN = 4'h7;

  // Register write/read request from the core
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } cis_sfr_req_t;

  // One-hot selects for one comparator
  typedef struct packed {
    logic [CIS_MUX_W-1:0] negSel;
    logic [CIS_MUX_W-1:0] posSel;
  } cis_mux_sel_t;

  // Whole state of the bank
  typedef struct packed {
    logic [7:0] selA;
    logic [7:0] selB;
    logic [7:0] rdData;
    logic rdValid;
    cis_mux_sel_t muxA;
    cis_mux_sel_t muxB;
  } cis_state_t;

endpackage : cis_pkg

`default_nettype wire

// ---- hw/cis_comparator_input_select.sv ----
// Comparator input select register bank: two 8-bit select registers and
// their one-hot decode toward the comparator analog multiplexers.
// Assumes a single-cycle special function register port from the core.
//
// Functional notes
// - Comparator A negative nibble: pins, reserved 0111/1000-1011, digital supply, ground.
// - Positive nibbles: eight even pins, reserved 1000-1011, battery, main supply.
// - Code 1100 on any nibble routes the touch sense reference level.
// - Code 1101 on any nibble routes half of the main supply.
`timescale 1ns/1ps
`default_nettype none

module cis_comparator_input_select (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register access port
  input wire cis_pkg::cis_sfr_req_t sfrReq,
  output logic [7:0] sfrRdData,
  output logic sfrRdValid,
  // Mux selects toward the analog multiplexers
  output cis_pkg::cis_mux_sel_t compAMux,
  output cis_pkg::cis_mux_sel_t compBMux,
  // Raw register contents
  output logic [7:0] compASelReg,
  output logic [7:0] compBSelReg
);
  import cis_pkg::*;

  // Whole state of the bank, registered in one stage
  cis_state_t state_ff;
  cis_state_t nxt_state;

  // Strobe and address qualification
  logic wrHitA;
  logic wrHitB;
  logic rdHitA;
  logic rdHitB;

  // Register contents as they will stand after this edge
  logic [7:0] nxt_selA;
  logic [7:0] nxt_selB;

  // Nibble slots: 0 A negative, 1 A positive, 2 B negative, 3 B positive
  logic [CIS_NIB_W-1:0] slotCode [4];
  logic [CIS_MUX_W-1:0] slotHot [4];

  // Negative nibble decode, one select line per code
  // Reserved codes drive no line, so the mux stays open
  // rather than tying two analog sources together
  function automatic logic [CIS_MUX_W-1:0] decodeNeg(input logic [CIS_NIB_W-1:0] code);
    logic [CIS_MUX_W-1:0] oneHot;
    oneHot = '0;
    unique case (code)
      4'h0: begin
        oneHot[4'h0] = 1'b1; // Port 0 pin 1
      end
      4'h1: begin
        oneHot[4'h1] = 1'b1; // Port 0 pin 3
      end
      4'h2: begin
        oneHot[4'h2] = 1'b1; // Port 0 pin 5
      end
      4'h3: begin
        oneHot[4'h3] = 1'b1; // Port 0 pin 7
      end
      4'h4: begin
        oneHot[4'h4] = 1'b1; // Port 1 pin 1
      end
      4'h5: begin
        oneHot[4'h5] = 1'b1; // Port 1 pin 3
      end
      CIS_NEG_LAST_PIN: begin
        oneHot[CIS_NEG_LAST_PIN] = 1'b1; // Port 1 pin 5
      end
      4'h7: begin
        oneHot = '0; // Reserved
      end
      4'h8: begin
        oneHot = '0; // Reserved
      end
      4'h9: begin
        oneHot = '0; // Reserved
      end
      4'hA: begin
        oneHot = '0; // Reserved
      end
      4'hB: begin
        oneHot = '0; // Reserved
      end
      CIS_CODE_TOUCH: begin
        oneHot[CIS_CODE_TOUCH] = 1'b1; // Touch sense reference
      end
      CIS_CODE_HALF: begin
        oneHot[CIS_CODE_HALF] = 1'b1; // Half of the main supply
      end
      CIS_CODE_NEG_DIG: begin
        oneHot[CIS_CODE_NEG_DIG] = 1'b1; // Digital supply
      end
      CIS_CODE_NEG_GND: begin
        oneHot[CIS_CODE_NEG_GND] = 1'b1; // Ground
      end
    endcase
    return oneHot;
  endfunction : decodeNeg

  // Positive nibble decode, one select line per code
  // Only 1000 to 1011 are reserved here; 0111 is a real pin
  function automatic logic [CIS_MUX_W-1:0] decodePos(input logic [CIS_NIB_W-1:0] code);
    logic [CIS_MUX_W-1:0] oneHot;
    oneHot = '0;
    unique case (code)
      4'h0: begin
        oneHot[4'h0] = 1'b1; // Port 0 pin 0
      end
      4'h1: begin
        oneHot[4'h1] = 1'b1; // Port 0 pin 2
      end
      4'h2: begin
        oneHot[4'h2] = 1'b1; // Port 0 pin 4
      end
      4'h3: begin
        oneHot[4'h3] = 1'b1; // Port 0 pin 6
      end
      4'h4: begin
        oneHot[4'h4] = 1'b1; // Port 1 pin 0
      end
      4'h5: begin
        oneHot[4'h5] = 1'b1; // Port 1 pin 2
      end
      4'h6: begin
        oneHot[4'h6] = 1'b1; // Port 1 pin 4
      end
      CIS_POS_LAST_PIN: begin
        oneHot[CIS_POS_LAST_PIN] = 1'b1; // Port 1 pin 6
      end
      4'h8: begin
        oneHot = '0; // Reserved
      end
      4'h9: begin
        oneHot = '0; // Reserved
      end
      4'hA: begin
        oneHot = '0; // Reserved
      end
      4'hB: begin
        oneHot = '0; // Reserved
      end
      CIS_CODE_TOUCH: begin
        oneHot[CIS_CODE_TOUCH] = 1'b1; // Touch sense reference
      end
      CIS_CODE_HALF: begin
        oneHot[CIS_CODE_HALF] = 1'b1; // Half of the main supply
      end
      CIS_CODE_POS_BAT: begin
        oneHot[CIS_CODE_POS_BAT] = 1'b1; // Battery supply
      end
      CIS_CODE_POS_MAIN: begin
        oneHot[CIS_CODE_POS_MAIN] = 1'b1; // Main supply
      end
    endcase
    return oneHot;
  endfunction : decodePos

  // Hits only count at a matching address; other addresses write nothing and a read there returns zero
  assign wrHitA = sfrReq.wrEn && (sfrReq.addr == CIS_ADDR_A);
  assign wrHitB = sfrReq.wrEn && (sfrReq.addr == CIS_ADDR_B);
  assign rdHitA = sfrReq.rdEn && (sfrReq.addr == CIS_ADDR_A);
  assign rdHitB = sfrReq.rdEn && (sfrReq.addr == CIS_ADDR_B);

  // Reset wins over a write in the same cycle
  assign nxt_selA = rst ? CIS_RESET_SEL : (wrHitA ? sfrReq.wrData : state_ff.selA);
  assign nxt_selB = rst ? CIS_RESET_SEL : (wrHitB ? sfrReq.wrData : state_ff.selB);

  // Slots decode the next contents, so the selects leave the same
  // flop stage as the register and never lag a write by a cycle
  assign slotCode[0] = nxt_selA[CIS_NEG_LSB +: CIS_NIB_W];
  assign slotCode[1] = nxt_selA[CIS_POS_LSB +: CIS_NIB_W];
  assign slotCode[2] = nxt_selB[CIS_NEG_LSB +: CIS_NIB_W];
  assign slotCode[3] = nxt_selB[CIS_POS_LSB +: CIS_NIB_W];

  // One decoder per slot; even slots feed negative inputs, odd slots positive
  for (genvar g = 0; g < 4; g++) begin : g_slot
    if (g % 2 == 0) begin : g_neg
      assign slotHot[g] = decodeNeg(slotCode[g]);
    end else begin : g_pos
      assign slotHot[g] = decodePos(slotCode[g]);
    end
  end

  // Next state: contents, read return and selects
  always_comb begin
    nxt_state = state_ff;
    nxt_state.selA = nxt_selA;
    nxt_state.selB = nxt_selB;
    // Valid answers every read outside reset, an unmapped one too
    nxt_state.rdValid = sfrReq.rdEn && !rst;
    // Unmapped reads and idle cycles return zero
    nxt_state.rdData = 8'h00;
    // Reads take the old value when a write hits the same register
    if (rdHitA && !rst) begin
      nxt_state.rdData = state_ff.selA;
    end
    if (rdHitB && !rst) begin
      nxt_state.rdData = state_ff.selB;
    end
    nxt_state.muxA.negSel = slotHot[0];
    nxt_state.muxA.posSel = slotHot[1];
    nxt_state.muxB.negSel = slotHot[2];
    nxt_state.muxB.posSel = slotHot[3];
  end

  // State register, synchronous reset folded into nxt_state
  always_ff @(posedge sys_clk) begin
    state_ff <= nxt_state;
  end

  // Outputs straight from flip-flops
  assign sfrRdData = state_ff.rdData;
  assign sfrRdValid = state_ff.rdValid;
  assign compAMux = state_ff.muxA;
  assign compBMux = state_ff.muxB;
  assign compASelReg = state_ff.selA;
  assign compBSelReg = state_ff.selB;

endmodule : cis_comparator_input_select

`default_nettype wire

// ---- sim/cis_monitor.sv ----
// Checker for the comparator input select bank.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cis_monitor (
  // Clock, reset, request
  input wire logic sys_clk,
  input wire logic rst,
  input wire cis_pkg::cis_sfr_req_t sfrReq,
  // Watched outputs
  input wire logic [7:0] sfrRdData,
  input wire logic sfrRdValid,
  input wire cis_pkg::cis_mux_sel_t compAMux,
  input wire cis_pkg::cis_mux_sel_t compBMux,
  input wire logic [7:0] compASelReg,
  input wire logic [7:0] compBSelReg
);
  import cis_pkg::*;
  // Reserved codes drive no line at all
  function automatic logic [15:0] hot(input logic [3:0] c, input logic neg);
    return (c[3:2] == 2'b10 || (neg && c == 4'h7)) ? 16'h0000 : 16'h0001 << c;
  endfunction : hot
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rd_a; sfrReq.rdEn && sfrReq.addr == CIS_ADDR_A; endsequence
  sequence s_wr_a; sfrReq.wrEn && sfrReq.addr == CIS_ADDR_A; endsequence
  a_neg_a_decode: assert property (compAMux.negSel == hot(compASelReg[7:4], 1'b1)) else $error("neg A");
  a_neg_b_decode: assert property (compBMux.negSel == hot(compBSelReg[7:4], 1'b1)) else $error("neg B");
  a_pos_decode: assert property (
    compAMux.posSel == hot(compASelReg[3:0], 1'b0) && compBMux.posSel == hot(compBSelReg[3:0], 1'b0))
    else $error("pos");
  a_touch_route: assert property (compBSelReg[3:0] == CIS_CODE_TOUCH |-> compBMux.posSel[12]) else $error("touch");
  a_half_route: assert property (compASelReg[7:4] == CIS_CODE_HALF |-> compAMux.negSel[13]) else $error("half");
  a_reset_ones: assert property (disable iff (1'b0)
    rst |=> compASelReg == CIS_RESET_SEL && compBSelReg == CIS_RESET_SEL) else $error("reset");
  a_write_b: assert property (
    sfrReq.wrEn && sfrReq.addr == CIS_ADDR_B |=> compBSelReg == $past(sfrReq.wrData)) else $error("write");
  a_write_a: assert property (s_wr_a |=> compASelReg == $past(sfrReq.wrData)) else $error("write A");
  a_read_idle: assert property (!sfrReq.rdEn |=> !sfrRdValid && sfrRdData == 8'h00) else $error("idle read");
  a_read_a: assert property (s_rd_a |=> sfrRdValid && sfrRdData == $past(compASelReg)) else $error("read");
endmodule : cis_monitor
bind cis_comparator_input_select cis_monitor i_cis_monitor (.sys_clk, .rst, .sfrReq, .sfrRdData, .sfrRdValid,
  .compAMux, .compBMux, .compASelReg, .compBSelReg);
`default_nettype wire

// ---- sim/test_comparator_input_select.sv ----
// Self-checking bench for the comparator input select bank.
// Drives the register port directly, no partner model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, b); end end
module test_comparator_input_select;
  import cis_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  cis_sfr_req_t sfrReq = '0;
  logic [7:0] sfrRdData, compASelReg, compBSelReg;
  logic sfrRdValid;
  cis_mux_sel_t compAMux, compBMux;
  int error_cnt = 0, checked = 0, cycles = 0;
  cis_comparator_input_select i_cis_comparator_input_select (.sys_clk, .rst, .sfrReq, .sfrRdData,
    .sfrRdValid, .compAMux, .compBMux, .compASelReg, .compBSelReg);
  always #4 sys_clk = ~sys_clk;
  // Hang guard, far above the fewer than a hundred cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  function automatic logic [15:0] hot(input logic [3:0] c, input logic neg);
    return (c[3:2] == 2'b10 || (neg && c == 4'h7)) ? 16'h0000 : 16'h0001 << c;
  endfunction : hot
  // One-cycle strobe, then look once its edge has landed
  task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) sfrReq <= {w, !w, a, d};
    @(posedge sys_clk) sfrReq <= '0;
    #1;
  endtask : req
  task automatic t_reset;
    `CHK({compASelReg, compBSelReg}, {2{CIS_RESET_SEL}})
    `CHK({compAMux, compBMux}, {4{16'h8000}})
    `CHK({sfrRdValid, sfrRdData}, 9'h000)
  endtask : t_reset
  task automatic t_sweep;
    for (int i = 0; i < 16; i++) begin
      req(1'b1, CIS_ADDR_A, {i[3:0], i[3:0]});
      req(1'b1, CIS_ADDR_B, {i[3:0], ~i[3:0]});
      `CHK(compAMux, {hot(i[3:0], 1'b1), hot(i[3:0], 1'b0)})
      `CHK(compBMux, {hot(i[3:0], 1'b1), hot(~i[3:0], 1'b0)})
      `CHK({compASelReg, compBSelReg}, {i[3:0], i[3:0], i[3:0], ~i[3:0]})
    end
  endtask : t_sweep
  task automatic t_read;
    req(1'b1, CIS_ADDR_A, 8'h5A);
    req(1'b1, 8'h9D, 8'h33);
    req(1'b0, CIS_ADDR_A, 8'h00);
    `CHK({sfrRdValid, sfrRdData}, 9'h15A)
    req(1'b0, CIS_ADDR_B, 8'h00);
    `CHK({sfrRdValid, sfrRdData}, 9'h1F0)
    req(1'b0, 8'h9D, 8'h00);
    `CHK({sfrRdValid, sfrRdData}, 9'h100)
    @(posedge sys_clk);
    #1;
    `CHK({sfrRdValid, sfrRdData}, 9'h000)
  endtask : t_read
  // Back-to-back write then read, then a read that meets a write
  task automatic t_order;
    @(posedge sys_clk) sfrReq <= {1'b1, 1'b0, CIS_ADDR_A, 8'hC3};
    @(posedge sys_clk) sfrReq <= {1'b0, 1'b1, CIS_ADDR_A, 8'h00};
    @(posedge sys_clk) sfrReq <= {1'b1, 1'b1, CIS_ADDR_B, 8'h3C};
    #1;
    `CHK({sfrRdValid, sfrRdData, compAMux}, {9'h1C3, 16'h1000, 16'h0008})
    @(posedge sys_clk) sfrReq <= '0;
    #1;
    `CHK({sfrRdValid, sfrRdData, compBSelReg, compBMux}, {9'h1F0, 8'h3C, 16'h0008, 16'h1000})
  endtask : t_order
  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_sweep();
    t_read();
    t_order();
    // Reset in mid-run
    @(posedge sys_clk) rst <= 1'b1;
    @(posedge sys_clk) rst <= 1'b0;
    #1;
    t_reset();
    tally_and_finish();
  end
endmodule : test_comparator_input_select
`default_nettype wire
